/* common/voice_seq_pkg.sv */
// constants and types for the voice trigger sequencer
// assumes a 200 MHz system clock and triggers already synchronous to it
// Functional notes
// - key voice playing: edge plus irretrigger inputs ignore new triggers.
// - without per-input reload, second input trigger during key voice acts as key trigger.
// - any jumping table disables per-input reload.
// - jumping plus looping: loop table restarts itself instead of ending.
// - power-on playback is edge/unhold/retrigger; any trigger preempts it.
// - priority: key input, then second input, then power-on playback.
// - release-jump: releasing trigger stops start table, goes to jump table.
// - release-jump option applies to all trigger inputs.
// - release-jump loop playing: retrigger inputs accept new triggers.
// - alarm-snooze: even tables alarm, odd silent snooze, steps irretrigger.
// - alarm without snooze: release-jump, level, retrigger, long debounce.
// - start table with jump ends: loop table begins without new trigger.
// - idle debounce: slow about 20 ms, fast about 50 us.
package voice_seq_pkg;
    localparam int          CLK_MHZ         = 200;
    localparam int          SLOW_DEB_MS     = 20;
    localparam int          FAST_DEB_US     = 50;
    localparam int          SLOW_DEB_CYC    = SLOW_DEB_MS * 1000 * CLK_MHZ;
    localparam int          FAST_DEB_CYC    = FAST_DEB_US * CLK_MHZ - 1;
    localparam logic [4:0]  TABLE_RST       = 5'h00;
    localparam logic [1:0]  SRC_NONE        = 2'h0;
    localparam logic [1:0]  SRC_KEY         = 2'h1;
    localparam logic [1:0]  SRC_TWO         = 2'h2;
    localparam logic [1:0]  SRC_PWR         = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_START = 4'b0010,
        ST_LOOP  = 4'b0100,
        ST_DONE  = 4'b1000
    } seq_state_e;
endpackage

/* rtl/trig_debounce.sv */
// debounce filter for one trigger input
// assumes input is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module trig_debounce
    import voice_seq_pkg::*;
#(
    parameter int SLOW_CYC = SLOW_DEB_CYC,
    parameter int FAST_CYC = FAST_DEB_CYC
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic raw_in,
    input  wire logic slow_sel,
    output logic      level_out
);
    // counts the filter cannot serve
    if (SLOW_CYC < 2 || FAST_CYC < 1 || FAST_CYC >= SLOW_CYC) begin : g_bad_counts
        $error("trig_debounce: bad debounce counts");
    end

    typedef struct packed {
        logic [31:0] cnt;
        logic        lvl;
    } deb_s;

    deb_s st_q;
    deb_s st_d;

    always_comb begin
        st_d = st_q;
        if (raw_in == st_q.lvl) begin
            st_d.cnt = 32'h0000_0000;
        end else if (st_q.cnt >= 32'(slow_sel ? SLOW_CYC : FAST_CYC)) begin
            st_d.lvl = raw_in;
            st_d.cnt = 32'h0000_0000;
        end else begin
            st_d.cnt = st_q.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign level_out = st_q.lvl;
endmodule
`default_nettype wire

/* rtl/voice_trigger_sequencer.sv */
// trigger arbitration and table sequencing for the voice player
// assumes the audio engine reports end of table on table_done
`timescale 1ns/1ps
`default_nettype none
module voice_trigger_sequencer
    import voice_seq_pkg::*;
#(
    parameter int SLOW_CYC = SLOW_DEB_CYC,
    parameter int FAST_CYC = FAST_DEB_CYC
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       key_input_pin,
    input  wire logic       second_input_pin,
    input  wire logic       power_on_playback,
    input  wire logic       release_jump_option,
    input  wire logic       alarm_snooze_option,
    input  wire logic       per_input_reload,
    input  wire logic       jump_configured,
    input  wire logic       loop_configured,
    input  wire logic [2:0] key_mode,
    input  wire logic [2:0] two_mode,
    input  wire logic       key_slow_deb,
    input  wire logic       two_slow_deb,
    input  wire logic [4:0] key_table,
    input  wire logic [4:0] two_table,
    input  wire logic [4:0] pwr_table,
    input  wire logic       table_done,
    output logic            playing,
    output logic            in_loop,
    output logic            mute,
    output logic [4:0]      table_sel,
    output logic [1:0]      voice_src,
    output logic            play_start
);
    // counts the filters cannot serve
    if (FAST_CYC < 1 || SLOW_CYC <= FAST_CYC) begin : g_bad_counts
        $error("voice_trigger_sequencer: bad debounce counts");
    end

    // mode bits: [2] level, [1] hold, [0] retrigger
    function automatic logic accept(input logic [2:0] m, input logic busy, input logic loop_rel);
        // edge irretrigger ignored while busy, retrigger accepted in released loop
        if (!busy)
            accept = 1'b1;
        else if (loop_rel && m[0])
            accept = 1'b1;
        else
            accept = m[0] | m[2];
    endfunction

    // level inputs fire while idle, every input fires on a rising edge
    function automatic logic trig_seen(input logic lvl_mode, input logic lvl, input logic rise, input logic busy);
        if (lvl_mode)
            trig_seen = (lvl & ~busy) | rise;
        else
            trig_seen = rise;
    endfunction

    logic [1:0] raw_trig;
    logic [1:0] slow_trig;
    logic [1:0] deb_lvl;
    logic       key_lvl;
    logic       two_lvl;

    assign raw_trig  = {second_input_pin, key_input_pin};
    assign slow_trig = {two_slow_deb, key_slow_deb};

    // one filter per trigger input
    for (genvar i = 0; i < 2; i++) begin : g_deb
        trig_debounce #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) u_trig_debounce (
            .clk       (clk),
            .sys_rst   (sys_rst),
            .raw_in    (raw_trig[i]),
            .slow_sel  (slow_trig[i]),
            .level_out (deb_lvl[i])
        );
    end

    assign key_lvl = deb_lvl[0];
    assign two_lvl = deb_lvl[1];

    typedef struct packed {
        seq_state_e fsm;
        logic [1:0] src;
        logic [4:0] tbl;
        logic       key_prev;
        logic       two_prev;
        logic       pwr_done;
        logic       released;
        logic       start;
        logic       mute;
        logic       play;
    } seq_s;

    seq_s st_q;
    seq_s st_d;

    logic       reload_on;
    logic       busy;
    logic       key_rise;
    logic       two_rise;
    logic       key_hit;
    logic       two_hit;
    logic       pwr_hit;
    logic       cur_lvl;
    logic [2:0] cur_mode;
    logic [2:0] two_eff;
    logic [4:0] two_sel;

    always_comb begin
        reload_on = per_input_reload & ~jump_configured;
        busy      = st_q.fsm == ST_START || st_q.fsm == ST_LOOP;
        key_rise  = key_lvl & ~st_q.key_prev;
        two_rise  = two_lvl & ~st_q.two_prev;
        // snooze tables are odd; their steps run irretrigger
        two_eff   = two_mode;
        if (alarm_snooze_option && st_q.tbl[0])
            two_eff[0] = 1'b0;
        cur_mode  = st_q.src == SRC_TWO ? two_eff : (st_q.src == SRC_PWR ? 3'b001 : key_mode);
        cur_lvl   = st_q.src == SRC_TWO ? two_lvl : (st_q.src == SRC_KEY ? key_lvl : 1'b1);
        key_hit   = trig_seen(key_mode[2], key_lvl, key_rise, busy)
                  & (st_q.src == SRC_PWR || accept(key_mode, busy, st_q.released));
        two_hit   = trig_seen(two_eff[2], two_lvl, two_rise, busy)
                  & (st_q.src == SRC_PWR || accept(st_q.src == SRC_KEY ? key_mode : two_eff,
                                                   busy, st_q.released));
        pwr_hit   = power_on_playback & ~st_q.pwr_done & ~busy;
        // second input during key voice acts as key when reload is off
        two_sel   = (!reload_on && st_q.src == SRC_KEY && busy) ? key_table : two_table;
    end

    always_comb begin
        st_d          = st_q;
        st_d.key_prev = key_lvl;
        st_d.two_prev = two_lvl;
        st_d.start    = 1'b0;
        if (key_hit) begin
            st_d.fsm      = ST_START;
            st_d.src      = SRC_KEY;
            st_d.tbl      = key_table;
            st_d.start    = 1'b1;
            st_d.released = 1'b0;
            st_d.pwr_done = 1'b1;
        end else if (two_hit) begin
            st_d.fsm      = ST_START;
            st_d.src      = two_sel == key_table && !reload_on && st_q.src == SRC_KEY ? SRC_KEY : SRC_TWO;
            st_d.tbl      = two_sel;
            st_d.start    = 1'b1;
            st_d.released = 1'b0;
            st_d.pwr_done = 1'b1;
        end else if (pwr_hit) begin
            st_d.fsm      = ST_START;
            st_d.src      = SRC_PWR;
            st_d.tbl      = pwr_table;
            st_d.start    = 1'b1;
            st_d.pwr_done = 1'b1;
        end else begin
            case (st_q.fsm)
                ST_IDLE: begin
                    st_d.src = SRC_NONE;
                end
                ST_START: begin
                    if (release_jump_option && st_q.src != SRC_PWR && !cur_lvl) begin
                        // both trigger inputs share release-jump behaviour, power-on playback does not
                        st_d.fsm      = jump_configured ? ST_LOOP : ST_DONE;
                        st_d.released = 1'b1;
                        st_d.start    = jump_configured;
                    end else if (cur_mode[1] && !release_jump_option && !cur_lvl) begin
                        st_d.fsm = ST_DONE;
                    end else if (table_done) begin
                        st_d.fsm   = jump_configured ? ST_LOOP : ST_DONE;
                        st_d.start = jump_configured;
                    end
                end
                ST_LOOP: begin
                    if (cur_mode[1] && !release_jump_option && !cur_lvl) begin
                        st_d.fsm = ST_DONE;
                    end else if (table_done) begin
                        st_d.fsm   = loop_configured ? ST_LOOP : ST_DONE;
                        st_d.start = loop_configured;
                    end
                end
                ST_DONE: begin
                    st_d.fsm      = ST_IDLE;
                    st_d.released = 1'b0;
                end
                default: begin
                    st_d.fsm = ST_IDLE;
                end
            endcase
        end
        // odd tables are silent snooze, loop tables greet
        st_d.mute = alarm_snooze_option && st_d.tbl[0] && st_d.fsm == ST_START;
        st_d.play = st_d.fsm == ST_START || st_d.fsm == ST_LOOP;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q          <= '0;
            st_q.fsm      <= ST_IDLE;
            st_q.src      <= SRC_NONE;
            st_q.tbl      <= TABLE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign playing    = st_q.play;
    assign in_loop    = st_q.fsm[2];
    assign mute       = st_q.mute;
    assign table_sel  = st_q.tbl;
    assign voice_src  = st_q.src;
    assign play_start = st_q.start;

    // second input table parity is the integrator's duty

    sequence s_loop_end;
        st_q.fsm == ST_LOOP && table_done && !key_hit && !two_hit
        && !(cur_mode[1] && !release_jump_option && !cur_lvl);
    endsequence

    AST_LOOP_REPEAT: assert property (@(posedge clk) disable iff (sys_rst)
        s_loop_end and loop_configured |=> in_loop && play_start)
        else $error("loop table did not restart");

    AST_JUMP_ON_END: assert property (@(posedge clk) disable iff (sys_rst)
        st_q.fsm == ST_START && table_done && jump_configured && !key_hit && !two_hit && !release_jump_option
        && !(cur_mode[1] && !cur_lvl) |=> in_loop && play_start)
        else $error("jump to loop table missed");

    AST_KEY_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
        key_hit |=> voice_src == SRC_KEY && table_sel == $past(key_table))
        else $error("key trigger lost priority");

    AST_PWR_PREEMPT: assert property (@(posedge clk) disable iff (sys_rst)
        st_q.src == SRC_PWR && busy && two_rise && !key_hit |=> voice_src != SRC_PWR && play_start)
        else $error("power-on playback not preempted");

    AST_EDGE_IRRE: assert property (@(posedge clk) disable iff (sys_rst)
        st_q.src == SRC_KEY && busy && !st_q.released && key_mode == 3'b000 |-> !key_hit && !two_hit)
        else $error("irretrigger edge accepted while busy");

    AST_REL_JUMP: assert property (@(posedge clk) disable iff (sys_rst)
        st_q.fsm == ST_START && st_q.src == SRC_KEY && release_jump_option && jump_configured
        && !key_lvl && !key_hit && !two_hit |=> in_loop)
        else $error("release jump missed");

    AST_RELOAD_OFF: assert property (@(posedge clk) disable iff (sys_rst)
        two_hit && !key_hit && !reload_on && st_q.src == SRC_KEY && busy |=> table_sel == $past(key_table))
        else $error("second input not treated as key");

    AST_HOLD_STOP: assert property (@(posedge clk) disable iff (sys_rst)
        busy && st_q.src == SRC_KEY && key_mode[1] && !release_jump_option && !key_lvl
        && !key_hit && !two_hit |=> !playing ##1 !playing)
        else $error("hold voice kept playing");

    sequence s_snooze_start;
        play_start && !in_loop;
    endsequence

    AST_MUTE_SNOOZE: assert property (@(posedge clk) disable iff (sys_rst)
        s_snooze_start |-> mute == ($past(alarm_snooze_option) && table_sel[0]))
        else $error("snooze mute does not follow table parity");

    sequence s_two_wins;
        two_hit && !key_hit;
    endsequence

    AST_TWO_OVER_PWR: assert property (@(posedge clk) disable iff (sys_rst)
        s_two_wins |=> play_start && voice_src != SRC_PWR)
        else $error("second input lost to power-on playback");

    sequence s_pwr_alone;
        pwr_hit && !key_hit && !two_hit;
    endsequence

    AST_PWR_LAST: assert property (@(posedge clk) disable iff (sys_rst)
        s_pwr_alone |=> play_start && voice_src == SRC_PWR && table_sel == $past(pwr_table))
        else $error("power-on playback did not start");

    sequence s_rel_loop_hit;
        st_q.fsm == ST_LOOP && st_q.released && st_q.src == SRC_KEY && key_mode[0] && (key_rise || two_rise);
    endsequence

    AST_RETRIG_LOOP: assert property (@(posedge clk) disable iff (sys_rst)
        s_rel_loop_hit |=> play_start && !in_loop)
        else $error("retrigger in released loop refused");

    sequence s_two_released;
        st_q.fsm == ST_START && st_q.src == SRC_TWO && !two_lvl && !key_hit && !two_hit;
    endsequence

    AST_REL_JUMP_TWO: assert property (@(posedge clk) disable iff (sys_rst)
        s_two_released and (release_jump_option && jump_configured) |=> in_loop && play_start)
        else $error("release jump missed on second input");

    sequence s_key_busy_two;
        two_hit && !key_hit && st_q.src == SRC_KEY && busy;
    endsequence

    AST_JUMP_NO_RELOAD: assert property (@(posedge clk) disable iff (sys_rst)
        s_key_busy_two and jump_configured |=> table_sel == $past(key_table))
        else $error("reload active although jumping is set");

    sequence s_done_quiet;
        st_q.fsm == ST_DONE && !key_hit && !two_hit && !pwr_hit;
    endsequence

    AST_DONE_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
        s_done_quiet |=> !playing && !play_start)
        else $error("playback did not end");
endmodule
`default_nettype wire

/* verification/audio_engine_model.sv */
// far-side audio engine stand-in: ends a table dur cycles after play_start
// assumes play_start is a one-cycle pulse on clk; dur of 0 never ends
`timescale 1ns/1ps
`default_nettype none
module audio_engine_model (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        play_start,
    input  wire logic [15:0] dur,
    output logic             table_done
);
    logic [15:0] cnt_q;
    always_ff @(posedge clk) begin
        table_done <= 1'b0;
        if (sys_rst || play_start) begin
            cnt_q <= sys_rst ? 16'h0000 : dur;
        end else if (cnt_q != 16'h0000) begin
            cnt_q      <= cnt_q - 16'h0001;
            table_done <= (cnt_q == 16'h0001);
        end
    end
endmodule
`default_nettype wire

/* verification/voice_trigger_sequencer_test.sv */
// self-checking bench for the voice trigger sequencer
// assumes short debounce counts and the audio engine model on table_done
`timescale 1ns/1ps
`default_nettype none
module voice_trigger_sequencer_test;
    import voice_seq_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, key_input_pin = 1'b0, second_input_pin = 1'b0;
    logic power_on_playback = 1'b1, release_jump_option = 1'b0, alarm_snooze_option = 1'b0;
    logic per_input_reload = 1'b0, jump_configured = 1'b0, loop_configured = 1'b0;
    logic key_slow_deb = 1'b0, two_slow_deb = 1'b0, table_done;
    logic [2:0] key_mode = 3'h0, two_mode = 3'h0;
    logic [4:0] key_table = 5'h01, two_table = 5'h02, pwr_table = 5'h03, table_sel;
    logic [15:0] dur = 16'h00c8;
    logic playing, in_loop, mute, play_start;
    logic [1:0] voice_src;
    int miscompares = 0, tests_run = 0, cycles = 0;

    voice_trigger_sequencer #(.SLOW_CYC(20), .FAST_CYC(3)) u_voice_trigger_sequencer (
        .clk, .sys_rst, .key_input_pin, .second_input_pin, .power_on_playback, .release_jump_option,
        .alarm_snooze_option, .per_input_reload, .jump_configured, .loop_configured, .key_mode, .two_mode,
        .key_slow_deb, .two_slow_deb, .key_table, .two_table, .pwr_table, .table_done, .playing, .in_loop,
        .mute, .table_sel, .voice_src, .play_start);
    audio_engine_model u_audio_engine_model (.clk, .sys_rst, .play_start, .dur, .table_done);

    initial forever #2.5 clk = ~clk;

    task automatic finish_test();
        $display("counts: %0d compared, %0d mismatched", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // returns 1 if play_start is seen within lim cycles
    task automatic wait_ps(input int lim, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(negedge clk);
            seen = (play_start === 1'b1);
        end
    endtask

    task automatic start_src(input logic [1:0] src, input logic [4:0] tbl);
        logic s;
        wait_ps(250, s);
        chk("play_start", 8'h01, {7'h00, s});
        chk("voice_src", {6'h00, src}, {6'h00, voice_src});
        chk("table_sel", {3'h0, tbl}, {3'h0, table_sel});
    endtask

    task automatic wait_idle(input int lim);
        for (int i = 0; i < lim && playing !== 1'b0; i++) begin
            @(negedge clk);
        end
        chk("playing", 8'h00, {7'h00, playing});
    endtask

    task automatic pins(input logic k, input logic t);
        @(negedge clk);
        key_input_pin    = k;
        second_input_pin = t;
    endtask

    task automatic do_reset();
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        chk("idle_out", 8'h00, {playing, in_loop, mute, play_start, voice_src, 2'h0});
    endtask

    initial begin
        logic s;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        start_src(SRC_PWR, 5'h03);
        power_on_playback = 1'b0;
        pins(1'b0, 1'b1);
        start_src(SRC_TWO, 5'h02);
        pins(1'b0, 1'b0);
        wait_idle(400);
        $display("test power-on preempt done");
        pins(1'b1, 1'b1);
        start_src(SRC_KEY, 5'h01);
        pins(1'b0, 1'b0);
        wait_idle(400);
        $display("test priority done");
        jump_configured = 1'b1;
        pins(1'b1, 1'b0);
        start_src(SRC_KEY, 5'h01);
        pins(1'b0, 1'b1);
        wait_ps(30, s);
        chk("refused", 8'h00, {7'h00, s});
        pins(1'b0, 1'b0);
        start_src(SRC_KEY, 5'h01);
        chk("in_loop", 8'h01, {7'h00, in_loop});
        wait_idle(400);
        $display("test jump done");
        loop_configured = 1'b1;
        pins(1'b1, 1'b0);
        start_src(SRC_KEY, 5'h01);
        pins(1'b0, 1'b0);
        repeat (2) start_src(SRC_KEY, 5'h01);
        chk("in_loop", 8'h01, {7'h00, in_loop});
        do_reset();
        $display("test looping done");
        loop_configured = 1'b0;
        release_jump_option = 1'b1;
        key_mode = 3'h1;
        two_mode = 3'h1;
        dur = 16'h012c;
        pins(1'b1, 1'b0);
        start_src(SRC_KEY, 5'h01);
        pins(1'b0, 1'b0);
        wait_ps(20, s);
        chk("rel_jump", 8'h03, {6'h00, s, in_loop});
        pins(1'b0, 1'b1);
        wait_ps(40, s);
        chk("retrig", 8'h01, {7'h00, s});
        pins(1'b0, 1'b0);
        wait_idle(400);
        pins(1'b0, 1'b1);
        start_src(SRC_TWO, 5'h02);
        pins(1'b0, 1'b0);
        wait_ps(20, s);
        chk("rel_two", 8'h03, {6'h00, s, in_loop});
        do_reset();
        $display("test release jump done");
        release_jump_option = 1'b0;
        per_input_reload = 1'b1;
        key_mode = 3'h4;
        pins(1'b1, 1'b0);
        start_src(SRC_KEY, 5'h01);
        pins(1'b1, 1'b1);
        repeat (30) @(negedge clk);
        chk("as_key", {SRC_KEY, 1'b0, key_table}, {voice_src, 1'b0, table_sel});
        pins(1'b0, 1'b0);
        do_reset();
        key_mode = 3'h2;
        pins(1'b1, 1'b0);
        start_src(SRC_KEY, 5'h01);
        pins(1'b0, 1'b0);
        wait_idle(20);
        $display("test second input and hold done");
        alarm_snooze_option = 1'b1;
        two_slow_deb = 1'b1;
        pins(1'b1, 1'b0);
        start_src(SRC_KEY, 5'h01);
        chk("mute_odd", 8'h01, {7'h00, mute});
        pins(1'b0, 1'b0);
        wait_idle(20);
        pins(1'b0, 1'b1);
        wait_ps(15, s);
        chk("slow_deb", 8'h00, {7'h00, s});
        start_src(SRC_TWO, 5'h02);
        chk("mute_even", 8'h00, {7'h00, mute});
        $display("test alarm done");
        finish_test();
    end
endmodule
`default_nettype wire
